// File: core/tmz_pkg.sv
// Package for the timer-zero block: APB register map, field positions, modes and timing.
// Assumes a 25 MHz core clock and a 32-bit APB master.
package tmz_pkg;
  localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMER_CTRL_OFS = 8'h04;
  localparam logic [7:0] LOW_BYTE_OFS = 8'h08;
  localparam logic [7:0] HIGH_BYTE_OFS = 8'h0c;
  localparam logic [7:0] SVC_ACK_OFS = 8'h10;
  // Mode control register lower nibble.
  localparam int MC_MODE_LO = 0;
  localparam int MC_MODE_HI = 1;
  localparam int MC_CNTSEL = 2;
  localparam int MC_GATE = 3;
  // Timer control register bits.
  localparam int TC_IRQ_TYPE = 0;
  localparam int TC_IRQ_FLAG = 1;
  localparam int TC_RUN0 = 4;
  localparam int TC_OVF0 = 5;
  localparam int TC_RUN1 = 6;
  localparam int TC_OVF1 = 7;
  // Service acknowledge word bits.
  localparam int ACK_OVF0 = 0;
  localparam int ACK_OVF1 = 1;
  localparam int ACK_EXT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [4:0] PRESCALE_FULL = 5'h1f;
  localparam logic [7:0] BYTE_FULL = 8'hff;
  localparam int PERIPH_DIV = 6;
  localparam logic [2:0] DIV_LAST = 3'(PERIPH_DIV - 1);
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    TMZ_MODE13 = 2'b00,
    TMZ_MODE16 = 2'b01,
    TMZ_MODE8R = 2'b10,
    TMZ_MODESPLIT = 2'b11
  } tmz_mode_t;
endpackage

// File: core/tmz_pin_sync.sv
// Three-stage pin synchroniser with an agreement check between the last two stages.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module tmz_pin_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      pinLevel
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       level_r;
  logic       level_nxt;

  always_comb begin
    sync_nxt = {sync_r[1:0], pinIn};
    level_nxt = level_r;
    // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2.
    if (sync_r[2] == sync_r[1]) begin
      level_nxt = sync_r[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_r <= 3'h7;
      level_r <= 1'b1;
    end else begin
      sync_r <= sync_nxt;
      level_r <= level_nxt;
    end
  end

  assign pinLevel = level_r;
endmodule
`default_nettype wire

// File: core/tmz_timer.sv
// Timer zero with four modes, an APB register port and overflow interrupt requests.
// Assumes an APB master on core_clk and external count and gate pins from outside the domain.
// What this block does
// - Running counts low byte from chosen input; in modes 0 and 1 low carries to high and high sets overflow.
// - Setting run keeps both count bytes unchanged.
// - Timer mode advances once per peripheral cycle, core clock divided by six.
// - Counter mode samples the pin per peripheral cycle; high then low increments.
// - Edge recognition takes two peripheral cycles; top rate one twelfth of the core clock.
// - Mode nibble holds gate, select, mode; control bits 0,1,4,5 for timer zero.
// - Gate clear: run alone enables; gate set: gate pin also controls.
// - Wrap from all ones to zeros sets overflow and requests interrupt.
// - Mode 0: five-bit prescaler in low byte clocks the 8-bit high byte.
// - Mode 1: low and high bytes cascade as one 16-bit counter.
// - Mode 2: low byte overflows, sets flag, reloads from high byte.
// - Overflow flag clears when the processor services the interrupt.
// - New reload value in high byte is used at next overflow.
// - Four modes, each as timer or event counter.
// - Mode 3: low byte own timer; high byte timer uses timer-one run and flag.
`timescale 1ns/100ps
`default_nettype none
module tmz_timer (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        countPin,
  input  wire logic        external_gate_pin,
  input  wire logic        irqServiceAck,
  output logic             ovfIrq,
  output logic             ovfIrqAux,
  output logic             extIrq
);
  logic [3:0]  mode_control_reg_r, mode_control_reg_nxt;
  logic [7:0]  timer_control_reg_r, timer_control_reg_nxt;
  logic [7:0]  count_low_byte_r, count_low_byte_nxt;
  logic [7:0]  count_high_byte_r, count_high_byte_nxt;
  logic [2:0]  div_r, div_nxt;
  logic        cntSample_r, cntSample_nxt;
  logic        gatePrev_r, gatePrev_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        cntLevel;
  logic        gateLevel;
  logic        periphTick;
  logic        wrAcc;
  logic        rdAcc;
  logic        mapped;
  logic        inc;
  logic        incHi;
  logic        countEnable;
  logic        fallEdge;
  tmz_pkg::tmz_mode_t mode;

  tmz_pin_sync uCntSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (countPin),
    .pinLevel (cntLevel)
  );

  tmz_pin_sync uGateSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (external_gate_pin),
    .pinLevel (gateLevel)
  );

  // The slave answers in the first access cycle, so pready is tied to the access phase.
  assign pready = psel && penable;
  assign wrAcc = psel && penable && pwrite;
  // Read data is captured at the end of the setup cycle, so it stands through the access phase.
  // A count read this way may be one core cycle old, which software cannot tell apart.
  assign rdAcc = psel && !penable && !pwrite;
  assign mapped = (paddr == tmz_pkg::MODE_CTRL_OFS) || (paddr == tmz_pkg::TIMER_CTRL_OFS) ||
                  (paddr == tmz_pkg::LOW_BYTE_OFS) || (paddr == tmz_pkg::HIGH_BYTE_OFS) ||
                  (paddr == tmz_pkg::SVC_ACK_OFS);
  assign pslverr = pready && !mapped;
  assign prdata = prdata_r;

  assign mode = tmz_pkg::tmz_mode_t'({mode_control_reg_r[tmz_pkg::MC_MODE_HI],
                                      mode_control_reg_r[tmz_pkg::MC_MODE_LO]});
  assign periphTick = (div_r == tmz_pkg::DIV_LAST);
  assign fallEdge = cntSample_r && !cntLevel;
  assign countEnable = timer_control_reg_r[tmz_pkg::TC_RUN0] &&
                       (!mode_control_reg_r[tmz_pkg::MC_GATE] || gateLevel);
  assign inc = periphTick && countEnable &&
               (mode_control_reg_r[tmz_pkg::MC_CNTSEL] ? fallEdge : 1'b1);
  // The split high-byte timer always counts peripheral cycles under the timer-one run bit.
  assign incHi = periphTick && timer_control_reg_r[tmz_pkg::TC_RUN1];

  always_comb begin
    div_nxt = periphTick ? 3'h0 : div_r + 3'h1;
    cntSample_nxt = periphTick ? cntLevel : cntSample_r;
    gatePrev_nxt = gateLevel;
  end

  always_comb begin
    mode_control_reg_nxt = mode_control_reg_r;
    timer_control_reg_nxt = timer_control_reg_r;
    count_low_byte_nxt = count_low_byte_r;
    count_high_byte_nxt = count_high_byte_r;
    prdata_nxt = prdata_r;
    // Software writes; run changes leave the count alone.
    if (wrAcc) begin
      case (paddr)
        tmz_pkg::MODE_CTRL_OFS: mode_control_reg_nxt = pwdata[3:0];
        tmz_pkg::TIMER_CTRL_OFS: begin
          timer_control_reg_nxt[tmz_pkg::TC_RUN0] = pwdata[tmz_pkg::TC_RUN0];
          timer_control_reg_nxt[tmz_pkg::TC_RUN1] = pwdata[tmz_pkg::TC_RUN1];
          timer_control_reg_nxt[tmz_pkg::TC_IRQ_TYPE] = pwdata[tmz_pkg::TC_IRQ_TYPE];
          timer_control_reg_nxt[tmz_pkg::TC_OVF0] = pwdata[tmz_pkg::TC_OVF0];
          timer_control_reg_nxt[tmz_pkg::TC_OVF1] = pwdata[tmz_pkg::TC_OVF1];
          timer_control_reg_nxt[tmz_pkg::TC_IRQ_FLAG] = pwdata[tmz_pkg::TC_IRQ_FLAG];
        end
        tmz_pkg::LOW_BYTE_OFS: count_low_byte_nxt = pwdata[7:0];
        tmz_pkg::HIGH_BYTE_OFS: count_high_byte_nxt = pwdata[7:0];
        tmz_pkg::SVC_ACK_OFS: begin
          if (pwdata[tmz_pkg::ACK_OVF0]) begin
            timer_control_reg_nxt[tmz_pkg::TC_OVF0] = 1'b0;
          end
          if (pwdata[tmz_pkg::ACK_OVF1]) begin
            timer_control_reg_nxt[tmz_pkg::TC_OVF1] = 1'b0;
          end
          if (pwdata[tmz_pkg::ACK_EXT]) begin
            timer_control_reg_nxt[tmz_pkg::TC_IRQ_FLAG] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // The interrupt controller's service strobe clears the overflow flag.
    if (irqServiceAck) begin
      timer_control_reg_nxt[tmz_pkg::TC_OVF0] = 1'b0;
    end
    // External interrupt flag: edge or level on the gate pin, set wins over clear.
    if (timer_control_reg_r[tmz_pkg::TC_IRQ_TYPE] ? (gatePrev_r && !gateLevel) : !gateLevel) begin
      timer_control_reg_nxt[tmz_pkg::TC_IRQ_FLAG] = 1'b1;
    end
    // Counting comes after the writes; presetting while running is undefined anyway.
    case (mode)
      tmz_pkg::TMZ_MODE13: begin
        if (inc) begin
          count_low_byte_nxt[4:0] = count_low_byte_r[4:0] + 5'h01;
          if (count_low_byte_r[4:0] == tmz_pkg::PRESCALE_FULL) begin
            count_high_byte_nxt = count_high_byte_r + 8'h01;
            if (count_high_byte_r == tmz_pkg::BYTE_FULL) begin
              timer_control_reg_nxt[tmz_pkg::TC_OVF0] = 1'b1;
            end
          end
        end
      end
      tmz_pkg::TMZ_MODE16: begin
        if (inc) begin
          count_low_byte_nxt = count_low_byte_r + 8'h01;
          if (count_low_byte_r == tmz_pkg::BYTE_FULL) begin
            count_high_byte_nxt = count_high_byte_r + 8'h01;
            if (count_high_byte_r == tmz_pkg::BYTE_FULL) begin
              timer_control_reg_nxt[tmz_pkg::TC_OVF0] = 1'b1;
            end
          end
        end
      end
      tmz_pkg::TMZ_MODE8R: begin
        if (inc) begin
          if (count_low_byte_r == tmz_pkg::BYTE_FULL) begin
            count_low_byte_nxt = count_high_byte_r;
            timer_control_reg_nxt[tmz_pkg::TC_OVF0] = 1'b1;
          end else begin
            count_low_byte_nxt = count_low_byte_r + 8'h01;
          end
        end
      end
      tmz_pkg::TMZ_MODESPLIT: begin
        if (inc) begin
          count_low_byte_nxt = count_low_byte_r + 8'h01;
          if (count_low_byte_r == tmz_pkg::BYTE_FULL) begin
            timer_control_reg_nxt[tmz_pkg::TC_OVF0] = 1'b1;
          end
        end
        if (incHi) begin
          count_high_byte_nxt = count_high_byte_r + 8'h01;
          if (count_high_byte_r == tmz_pkg::BYTE_FULL) begin
            timer_control_reg_nxt[tmz_pkg::TC_OVF1] = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    if (rdAcc) begin
      case (paddr)
        tmz_pkg::MODE_CTRL_OFS: prdata_nxt = {28'h0000000, mode_control_reg_r};
        tmz_pkg::TIMER_CTRL_OFS: prdata_nxt = {24'h000000, timer_control_reg_r};
        tmz_pkg::LOW_BYTE_OFS: prdata_nxt = {24'h000000, count_low_byte_r};
        tmz_pkg::HIGH_BYTE_OFS: prdata_nxt = {24'h000000, count_high_byte_r};
        default: prdata_nxt = tmz_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_control_reg_r <= tmz_pkg::CTRL_RESET[3:0];
      timer_control_reg_r <= tmz_pkg::CTRL_RESET;
      count_low_byte_r <= tmz_pkg::COUNT_RESET;
      count_high_byte_r <= tmz_pkg::COUNT_RESET;
      div_r <= 3'h0;
      cntSample_r <= 1'b1;
      gatePrev_r <= 1'b1;
      prdata_r <= tmz_pkg::UNMAPPED_DATA;
    end else begin
      mode_control_reg_r <= mode_control_reg_nxt;
      timer_control_reg_r <= timer_control_reg_nxt;
      count_low_byte_r <= count_low_byte_nxt;
      count_high_byte_r <= count_high_byte_nxt;
      div_r <= div_nxt;
      cntSample_r <= cntSample_nxt;
      gatePrev_r <= gatePrev_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // The interrupt requests are flag bits, so they leave the block glitch-free from flip-flops.
  assign ovfIrq = timer_control_reg_r[tmz_pkg::TC_OVF0];
  assign ovfIrqAux = timer_control_reg_r[tmz_pkg::TC_OVF1];
  assign extIrq = timer_control_reg_r[tmz_pkg::TC_IRQ_FLAG];

  // All checks sit in the core clock domain and stay quiet while reset is held.
  a_tick_period: assert property (@(posedge core_clk) disable iff (!rst_n)
    periphTick |=> !periphTick [*5] ##1 periphTick) else $error("tick period wrong");
  a_run_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!timer_control_reg_r[tmz_pkg::TC_RUN0] && !wrAcc && mode != tmz_pkg::TMZ_MODESPLIT)
    |=> $stable(count_low_byte_r)) else $error("count moved while stopped");
  a_mode1_ovf: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == tmz_pkg::TMZ_MODE16 && inc && count_low_byte_r == 8'hff &&
     count_high_byte_r == 8'hff && !irqServiceAck)
    |=> ovfIrq && count_low_byte_r == 8'h00 && count_high_byte_r == 8'h00)
    else $error("16-bit wrap wrong");
  a_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == tmz_pkg::TMZ_MODE8R && inc && count_low_byte_r == 8'hff && !wrAcc)
    |=> count_low_byte_r == $past(count_high_byte_r) && $stable(count_high_byte_r))
    else $error("reload wrong");
  a_mode0_carry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == tmz_pkg::TMZ_MODE13 && inc && count_low_byte_r[4:0] == 5'h1f && !wrAcc)
    |=> count_high_byte_r == $past(count_high_byte_r) + 8'h01) else $error("prescale carry");
  a_svc_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (irqServiceAck && !inc && !wrAcc) |=> !ovfIrq) else $error("flag not cleared");
  a_gate_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_control_reg_r[tmz_pkg::MC_GATE] && !gateLevel) |-> !inc) else $error("gate ignored");
  a_edge_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_control_reg_r[tmz_pkg::MC_CNTSEL] && inc) |-> (cntSample_r && !cntLevel))
    else $error("count without edge");
  a_timer_inc: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!mode_control_reg_r[tmz_pkg::MC_CNTSEL] && periphTick && countEnable) |-> inc)
    else $error("timer missed tick");
  a_start_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wrAcc && paddr == tmz_pkg::TIMER_CTRL_OFS && !timer_control_reg_r[tmz_pkg::TC_RUN0] &&
     mode != tmz_pkg::TMZ_MODESPLIT) |=> $stable(count_low_byte_r) && $stable(count_high_byte_r))
    else $error("start moved count");
  a_stop_still: assert property (@(posedge core_clk) disable iff (!rst_n)
    !timer_control_reg_r[tmz_pkg::TC_RUN0] |-> !inc) else $error("count while stopped");
  a_gate_free: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!mode_control_reg_r[tmz_pkg::MC_GATE] && timer_control_reg_r[tmz_pkg::TC_RUN0] &&
     !mode_control_reg_r[tmz_pkg::MC_CNTSEL] && periphTick) |-> inc)
    else $error("run alone ignored");
  a_mode16_carry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == tmz_pkg::TMZ_MODE16 && inc && count_low_byte_r == 8'hff && !wrAcc)
    |=> count_high_byte_r == $past(count_high_byte_r) + 8'h01) else $error("16-bit carry");
  a_mode0_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == tmz_pkg::TMZ_MODE13 && inc && !wrAcc) |=> $stable(count_low_byte_r[7:5]))
    else $error("prescale upper bits moved");
  a_mode2_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == tmz_pkg::TMZ_MODE8R && !wrAcc) |=> $stable(count_high_byte_r))
    else $error("reload source moved");
  a_ovf_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ovfIrq && !irqServiceAck && !wrAcc) |=> ovfIrq) else $error("flag dropped");
  a_split_aux: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == tmz_pkg::TMZ_MODESPLIT && incHi && count_high_byte_r == 8'hff) |=> ovfIrqAux)
    else $error("split flag missing");
  a_ext_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!timer_control_reg_r[tmz_pkg::TC_IRQ_TYPE] && !gateLevel) |=> extIrq)
    else $error("level request missed");

  // Covers for the main scenarios: overflow in modes 1 and 2, the split high-byte overflow, event counting and gated counting.
  c_ovf16: cover property (@(posedge core_clk) mode == tmz_pkg::TMZ_MODE16 && $rose(ovfIrq));
  c_reload: cover property (@(posedge core_clk) mode == tmz_pkg::TMZ_MODE8R && $rose(ovfIrq));
  c_event: cover property (@(posedge core_clk) mode_control_reg_r[tmz_pkg::MC_CNTSEL] && inc);
  c_split: cover property (@(posedge core_clk)
    mode == tmz_pkg::TMZ_MODESPLIT && $rose(ovfIrqAux));
  c_gated: cover property (@(posedge core_clk) mode_control_reg_r[tmz_pkg::MC_GATE] && inc);
endmodule
`default_nettype wire

// File: testbench/tmz_far_side.sv
// Far-side model: external count source and the interrupt controller.
// Assumes core_clk from the bench and the timer's overflow flag as input.
`timescale 1ns/100ps
`default_nettype none
module tmz_far_side (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       pulseGo,
  input  wire logic [7:0] pulseCount,
  input  wire logic       ovfIrq,
  output logic            countPin,
  output logic            busy,
  output logic            irqServiceAck
);
  logic [8:0] left;
  logic [2:0] hold;
  logic [1:0] ackCnt;
  assign busy = (left != 9'h000);
  always @(posedge core_clk) begin
    irqServiceAck <= 1'b0;
    if (!rst_n) begin
      countPin <= 1'b1;
      left <= 9'h000;
      hold <= 3'h0;
      ackCnt <= 2'h0;
    end else begin
      if (pulseGo) begin
        left <= {pulseCount, 1'b0};
      end else if (busy) begin
        hold <= hold + 3'h1;
        // Eight cycles a level, so a slow sampler never misses one.
        if (hold == 3'h7) begin
          countPin <= ~countPin;
          left <= left - 9'h001;
        end
      end
      ackCnt <= ovfIrq ? ackCnt + 2'h1 : 2'h0;
      if (ackCnt == 2'h3) begin
        irqServiceAck <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the timer-zero block over APB.
// Assumes the far-side model drives the count pin and services interrupts.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, gatePin = 1'b1, pulseGo = 1'b0, rdErr;
  logic [7:0] paddr = 8'h00, pulseCount = 8'h00, k, p;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic pready, pslverr, countPin, irqServiceAck, ovfIrq, ovfIrqAux, extIrq, busy;
  int fails = 0, checks = 0, cyc = 0, n, seed = 83987;
  logic [7:0] tbl [4][3] = '{'{8'h01, 8'hfe, 8'hff}, '{8'h00, 8'h1e, 8'hff},
                             '{8'h02, 8'hfe, 8'ha5}, '{8'h03, 8'hfe, 8'hff}};
  always #20 core_clk = ~core_clk;
  tmz_timer u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countPin(countPin), .external_gate_pin(gatePin),
    .irqServiceAck(irqServiceAck), .ovfIrq(ovfIrq), .ovfIrqAux(ovfIrqAux), .extIrq(extIrq));
  tmz_far_side u_far (.core_clk(core_clk), .rst_n(rst_n), .pulseGo(pulseGo),
    .pulseCount(pulseCount), .ovfIrq(ovfIrq), .countPin(countPin), .busy(busy),
    .irqServiceAck(irqServiceAck));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    // Status and read data are taken at the edge that completes the access.
    rdErr = pslverr;
    rdData = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitFlag(input logic aux, input logic lvl, input int lim);
    n = 0;
    while ((aux ? ovfIrqAux : ovfIrq) !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  function automatic logic inWin(input int got, input int ticks);
    return got >= 6 * ticks - 4 && got <= 6 * ticks + 1;
  endfunction
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      `CHK("reset_value", 32'h0, rdData)
    end
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped_err", 1'b1, rdErr)
    `CHK("unmapped_data", tmz_pkg::UNMAPPED_DATA, rdData)
    // Gated start: bytes keep their preset and stay still while the gate is low.
    gatePin <= 1'b0;
    apb(1'b1, tmz_pkg::MODE_CTRL_OFS, 32'h09);
    apb(1'b1, tmz_pkg::LOW_BYTE_OFS, 32'hfe);
    apb(1'b1, tmz_pkg::HIGH_BYTE_OFS, 32'hff);
    apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h10);
    apb(1'b0, tmz_pkg::LOW_BYTE_OFS, 32'h0);
    `CHK("start_low", 32'hfe, rdData)
    apb(1'b0, tmz_pkg::HIGH_BYTE_OFS, 32'h0);
    `CHK("start_high", 32'hff, rdData)
    repeat (40) @(negedge core_clk);
    `CHK("gated_off", 1'b0, ovfIrq)
    `CHK("ext_level", 1'b1, extIrq)
    @(posedge core_clk);
    gatePin <= 1'b1;
    waitFlag(1'b0, 1'b1, 30);
    `CHK("gated_on", 1'b1, ovfIrq)
    waitFlag(1'b0, 1'b0, 10);
    `CHK("svc_clear", 1'b0, ovfIrq)
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h0);
      apb(1'b1, tmz_pkg::MODE_CTRL_OFS, {24'h0, tbl[m][0]});
      apb(1'b1, tmz_pkg::LOW_BYTE_OFS, {24'h0, tbl[m][1]});
      apb(1'b1, tmz_pkg::HIGH_BYTE_OFS, {24'h0, tbl[m][2]});
      apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, (m == 3) ? 32'h40 : 32'h10);
      waitFlag(m == 3, 1'b1, 40);
      `CHK("ovf_time", 1'b1, inWin(n, (m == 3) ? 1 : 2))
      apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h0);
      apb(1'b0, tmz_pkg::HIGH_BYTE_OFS, 32'h0);
      `CHK("wrap_high", {24'h0, (m == 2) ? tbl[m][2] : 8'h00}, rdData)
      apb(1'b0, tmz_pkg::LOW_BYTE_OFS, 32'h0);
      `CHK("wrap_low", {24'h0, (m >= 2) ? tbl[m][2 - m / 3] : 8'h00}, rdData)
      apb(1'b1, tmz_pkg::SVC_ACK_OFS, 32'h3);
      @(negedge core_clk);
      `CHK("aux_clear", 1'b0, ovfIrqAux)
    end
    // Reload value changed while running takes effect at the next wrap.
    apb(1'b1, tmz_pkg::MODE_CTRL_OFS, 32'h02);
    apb(1'b1, tmz_pkg::LOW_BYTE_OFS, 32'hfe);
    apb(1'b1, tmz_pkg::HIGH_BYTE_OFS, 32'hfd);
    apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h10);
    waitFlag(1'b0, 1'b1, 40);
    apb(1'b1, tmz_pkg::HIGH_BYTE_OFS, 32'hf0);
    waitFlag(1'b0, 1'b0, 10);
    waitFlag(1'b0, 1'b1, 40);
    `CHK("reload_ovf", 1'b1, ovfIrq)
    apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h0);
    apb(1'b0, tmz_pkg::LOW_BYTE_OFS, 32'h0);
    `CHK("reload_new", 32'hf0, rdData)
    apb(1'b0, tmz_pkg::HIGH_BYTE_OFS, 32'h0);
    `CHK("reload_keep", 32'hf0, rdData)
    // Event counting: every falling edge of the pin adds exactly one.
    apb(1'b1, tmz_pkg::MODE_CTRL_OFS, 32'h05);
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 8'h01 : 8'h01 + 8'($random(seed) & 7);
      p = 8'($random(seed) & 8'h7f);
      apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h0);
      apb(1'b1, tmz_pkg::LOW_BYTE_OFS, {24'h0, p});
      apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h10);
      @(posedge core_clk);
      pulseGo <= 1'b1;
      pulseCount <= k;
      @(posedge core_clk);
      pulseGo <= 1'b0;
      // The model loads its burst at this edge, so busy is looked at half a cycle on.
      @(negedge core_clk);
      for (int w = 0; w < 400 && busy !== 1'b0; w++) @(negedge core_clk);
      repeat (16) @(posedge core_clk);
      apb(1'b1, tmz_pkg::TIMER_CTRL_OFS, 32'h0);
      apb(1'b0, tmz_pkg::LOW_BYTE_OFS, 32'h0);
      `CHK("event_count", {24'h0, p + k}, rdData)
    end
    final_report();
  end
endmodule
`default_nettype wire
